// ===== hdl/plc_top.sv
// Functional notes
// - After power-up every read and write is refused while default lock holds.
// - Unlock only by code write to 0x24 within 8 ms of power-up.
// - Accepted unlock keeps access open for rest of powered session.
// - Supply cycle reinstates default lock automatically.
// - Permanent lock bit set plus supply cycle refuses all accesses forever.
// - Under permanent lock unlock code ignored; no way to clear it.
// - Release counter starts when supply reaches upper threshold.
// - Output high impedance until counter expires with supply held above upper.
// - Supply falling to lower threshold asserts reset, output high impedance.
// - After a dip, full power-on delay again before normal output.
// - Lost ground puts output in high impedance, no field response.
// - Restored ground returns output to normal operation by itself.
// - Unlock code travels in dedicated access-code write command.
`timescale 1ns/10ps
module plc_top #(
  parameter logic [plc_pkg::TMR_W-1:0] UNLOCK_WINDOW_CYC =
    plc_pkg::TMR_W'(plc_pkg::UNLOCK_WINDOW_CYC),
  parameter logic [plc_pkg::TMR_W-1:0] RELEASE_CYC       =
    plc_pkg::TMR_W'(plc_pkg::RELEASE_CYC),
  parameter logic [plc_pkg::KEY_W-1:0] UNLOCK_KEY        = plc_pkg::UNLOCK_KEY_DEF
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               supply_above_rise_in,
  input  wire logic               supply_above_fall_in,
  input  wire logic               ground_ok_in,
  input  wire logic               perm_lock_bit_in,
  input  wire logic               cmd_valid_in,
  input  wire plc_pkg::plc_cmd_t  cmd_in,
  output logic                    por_reset_n_out,
  output logic                    out_drive_en_out,
  output logic                    field_track_out,
  output plc_pkg::plc_grant_t     grant_out,
  output plc_pkg::plc_cmd_t       grant_cmd_out,
  output logic                    cmd_refused_out,
  output logic                    unlock_accepted_out,
  output plc_pkg::plc_lock_state_t lock_state_out,
  output logic                    window_open_out
);

  // ---------------------------------------------------------------
  // Comparator and ground inputs
  // ---------------------------------------------------------------
  logic [plc_pkg::SYNC_W-1:0] raw_levels;
  logic [plc_pkg::SYNC_W-1:0] sync_levels;
  logic                       above_rise_s;
  logic                       above_fall_s;
  logic                       ground_ok_s;

  // Analog comparators are asynchronous to the core clock
  assign raw_levels   = {ground_ok_in, supply_above_fall_in, supply_above_rise_in};
  assign above_rise_s = sync_levels[0];
  assign above_fall_s = sync_levels[1];
  assign ground_ok_s  = sync_levels[2];

  plc_sync #(
    .W (plc_pkg::SYNC_W)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    (raw_levels),
    .sync_out    (sync_levels)
  );

  // ---------------------------------------------------------------
  // Power-on sequencing
  // ---------------------------------------------------------------
  plc_pkg::plc_por_state_t por_q;
  plc_pkg::plc_por_state_t next_por;
  logic                    release_done;
  logic                    window_done;
  logic                    session_on;

  assign session_on = (por_q != plc_pkg::PS_OFF);

  // Release counter runs only in COUNT, restarts from zero on any abort
  plc_timer #(
    .LIMIT (RELEASE_CYC)
  ) u_release (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .run_in      (por_q == plc_pkg::PS_COUNT),
    .done_out    (release_done)
  );

  // Unlock window counts from the supply rise for the whole session
  plc_timer #(
    .LIMIT (UNLOCK_WINDOW_CYC)
  ) u_window (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .run_in      (session_on),
    .done_out    (window_done)
  );

  // Next power state from the synchronised comparator levels
  always_comb begin
    next_por = por_q;
    case (por_q)
      plc_pkg::PS_OFF: begin
        if (above_rise_s) begin
          next_por = plc_pkg::PS_COUNT;
        end
      end
      plc_pkg::PS_COUNT: begin
        // Supply must stay above the upper threshold the whole count
        if (!above_rise_s) begin
          next_por = plc_pkg::PS_OFF;
        end else if (release_done) begin
          next_por = plc_pkg::PS_RUN;
        end
      end
      plc_pkg::PS_RUN: begin
        // Hysteresis: only the lower threshold ends a running session
        if (!above_fall_s) begin
          next_por = plc_pkg::PS_OFF;
        end
      end
      default: begin
        next_por = plc_pkg::PS_OFF;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_q <= plc_pkg::PS_OFF;
    end else begin
      por_q <= next_por;
    end
  end

  // Pin drive follows the next state so it switches with the state
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_reset_n_out  <= 1'b0;
      out_drive_en_out <= 1'b0;
      field_track_out  <= 1'b0;
    end else begin
      por_reset_n_out  <= (next_por == plc_pkg::PS_RUN);
      out_drive_en_out <= (next_por == plc_pkg::PS_RUN) && ground_ok_s;
      field_track_out  <= (next_por == plc_pkg::PS_RUN) && ground_ok_s;
    end
  end

  // ---------------------------------------------------------------
  // Lock state
  // ---------------------------------------------------------------
  plc_pkg::plc_lock_state_t lock_q;
  logic                     power_up_edge;
  logic                     code_write;
  logic                     code_match;
  logic                     window_open;

  assign power_up_edge = (por_q == plc_pkg::PS_OFF) && (next_por == plc_pkg::PS_COUNT);
  assign window_open   = session_on && !window_done;
  // Only the dedicated access command addressed to the key register counts
  assign code_write    = cmd_valid_in && (cmd_in.kind == plc_pkg::CMD_ACCESS) &&
                         (cmd_in.addr == plc_pkg::UNLOCK_KEY_ADDR);
  assign code_match    = (cmd_in.data == UNLOCK_KEY);

  // Lock bit is sampled only at power-up, so setting it takes a supply cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_q <= plc_pkg::LK_LOCKED;
    end else if (!session_on) begin
      if (power_up_edge && perm_lock_bit_in) begin
        lock_q <= plc_pkg::LK_PERM;
      end else begin
        lock_q <= plc_pkg::LK_LOCKED;
      end
    end else begin
      case (lock_q)
        plc_pkg::LK_LOCKED: begin
          if (code_write && code_match && window_open) begin
            lock_q <= plc_pkg::LK_OPEN;
          end
        end
        plc_pkg::LK_OPEN: begin
          lock_q <= plc_pkg::LK_OPEN;
        end
        plc_pkg::LK_PERM: begin
          lock_q <= plc_pkg::LK_PERM;
        end
        default: begin
          lock_q <= plc_pkg::LK_LOCKED;
        end
      endcase
    end
  end

  // Status mirrors
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      window_open_out <= 1'b0;
      lock_state_out  <= plc_pkg::LK_LOCKED;
    end else begin
      window_open_out <= window_open;
      lock_state_out  <= lock_q;
    end
  end

  // ---------------------------------------------------------------
  // Access gating
  // ---------------------------------------------------------------
  logic access_ok;

  // Open means unlocked in a live session; the permanent lock never opens
  assign access_ok = session_on && (lock_q == plc_pkg::LK_OPEN);

  // One-cycle grants and refusals, command copied beside the grant
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      grant_out           <= '0;
      grant_cmd_out       <= '0;
      cmd_refused_out     <= 1'b0;
      unlock_accepted_out <= 1'b0;
    end else begin
      grant_out           <= '0;
      cmd_refused_out     <= 1'b0;
      unlock_accepted_out <= 1'b0;
      if (cmd_valid_in) begin
        grant_cmd_out <= cmd_in;
        case (cmd_in.kind)
          plc_pkg::CMD_ACCESS: begin
            // Late, wrong or permanently locked code writes are refused unless the lock is already open
            if (code_write && code_match && window_open &&
                lock_q == plc_pkg::LK_LOCKED) begin
              unlock_accepted_out <= 1'b1;
            end else if (lock_q != plc_pkg::LK_OPEN) begin
              cmd_refused_out <= 1'b1;
            end
          end
          plc_pkg::CMD_VOL_WR: begin
            grant_out.vol_wr <= access_ok;
            cmd_refused_out  <= !access_ok;
          end
          plc_pkg::CMD_NV_WR: begin
            grant_out.nv_wr <= access_ok;
            cmd_refused_out <= !access_ok;
          end
          plc_pkg::CMD_READ: begin
            grant_out.rd    <= access_ok;
            cmd_refused_out <= !access_ok;
          end
          default: begin
            cmd_refused_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_NO_GRANT_LOCKED: assert property (
    (cmd_valid_in && lock_q != plc_pkg::LK_OPEN) |=> (grant_out == '0))
    else $error("access granted while locked");

  AST_UNLOCK_CAUSE: assert property (
    unlock_accepted_out |-> $past(code_write && code_match && window_open))
    else $error("unlock accepted without timely matching code");

  AST_OPEN_STAYS: assert property (
    (lock_q == plc_pkg::LK_OPEN && next_por != plc_pkg::PS_OFF && session_on)
    |=> lock_q == plc_pkg::LK_OPEN)
    else $error("open session closed without supply cycle");

  AST_RELOCK_OFF: assert property (
    (por_q == plc_pkg::PS_OFF) |=> (lock_q != plc_pkg::LK_OPEN))
    else $error("lock not reinstated after power loss");

  AST_PERM_NO_GRANT: assert property (
    (lock_q == plc_pkg::LK_PERM && cmd_valid_in) |=> (grant_out == '0) && cmd_refused_out)
    else $error("access under permanent lock");

  AST_PERM_IGNORES_KEY: assert property (
    (lock_q == plc_pkg::LK_PERM && session_on) |=> lock_q == plc_pkg::LK_PERM
    && !unlock_accepted_out)
    else $error("permanent lock left or key honoured");

  AST_COUNT_START: assert property (
    (por_q == plc_pkg::PS_OFF && above_rise_s) |=> por_q == plc_pkg::PS_COUNT)
    else $error("release counter not started at threshold");

  AST_RUN_AFTER_COUNT: assert property (
    $rose(por_q == plc_pkg::PS_RUN) |-> $past(por_q == plc_pkg::PS_COUNT && release_done
    && above_rise_s))
    else $error("left reset before counter expired");

  AST_FALL_HIZ: assert property (
    (por_q == plc_pkg::PS_RUN && !above_fall_s) |=> por_q == plc_pkg::PS_OFF
    && !out_drive_en_out && !por_reset_n_out)
    else $error("output still driven below lower threshold");

  AST_DIP_FULL_DELAY: assert property (
    (por_q == plc_pkg::PS_OFF) ##1 (por_q == plc_pkg::PS_COUNT) |-> !out_drive_en_out[*2])
    else $error("output driven without full power-on delay");

  AST_GROUND_LOST: assert property (
    !ground_ok_s |=> !out_drive_en_out && !field_track_out)
    else $error("output driven with ground lost");

  AST_GROUND_BACK: assert property (
    (ground_ok_s && next_por == plc_pkg::PS_RUN) |=> out_drive_en_out && field_track_out)
    else $error("output not restored after ground return");

  AST_BAD_KEY: assert property (
    (lock_q == plc_pkg::LK_LOCKED && code_write && !code_match) |=> lock_q != plc_pkg::LK_OPEN)
    else $error("mismatched key opened lock");

endmodule

// ===== hdl/plc_pkg.sv
package plc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 5;
  // Unlock window measured from power-up
  localparam int UNLOCK_WINDOW_NS   = 8000000;
  // Release counter time; no figure fixed, plain default
  localparam int RELEASE_TIME_NS    = 64000;
  // Longest time rounds down
  localparam int UNLOCK_WINDOW_CYC  = UNLOCK_WINDOW_NS / CLK_PERIOD_NS;
  // Least time rounds up
  localparam int RELEASE_CYC        = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W              = 24;

  // ---------------------------------------------------------------
  // Command and key layout
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 6;
  localparam int          KEY_W           = 30;
  localparam logic [5:0]  UNLOCK_KEY_ADDR = 6'h24;
  // Arbitrary neutral value, replace per customer
  localparam logic [29:0] UNLOCK_KEY_DEF  = 30'h2aaa5555;
  localparam int          SYNC_W          = 3;

  typedef enum logic [1:0] {
    CMD_ACCESS = 2'b00,
    CMD_VOL_WR = 2'b01,
    CMD_NV_WR  = 2'b10,
    CMD_READ   = 2'b11
  } plc_cmd_kind_t;

  typedef struct packed {
    plc_cmd_kind_t     kind;
    logic [ADDR_W-1:0] addr;
    logic [KEY_W-1:0]  data;
  } plc_cmd_t;

  typedef struct packed {
    logic vol_wr;
    logic nv_wr;
    logic rd;
  } plc_grant_t;

  typedef enum logic [1:0] {
    PS_OFF   = 2'b00,
    PS_COUNT = 2'b01,
    PS_RUN   = 2'b10
  } plc_por_state_t;

  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_OPEN   = 2'b01,
    LK_PERM   = 2'b10
  } plc_lock_state_t;

endpackage

// ===== hdl/plc_sync.sv
`timescale 1ns/10ps
module plc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // ---------------------------------------------------------------
  // Two flops per bit; first stage feeds only the second
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end

endmodule

// ===== hdl/plc_timer.sv
`timescale 1ns/10ps
module plc_timer #(
  parameter logic [plc_pkg::TMR_W-1:0] LIMIT = 24'h000010
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic run_in,
  output logic      done_out
);

  logic [plc_pkg::TMR_W-1:0] count;

  // ---------------------------------------------------------------
  // Counts while run is high; done sticks until run drops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count    <= '0;
      done_out <= 1'b0;
    end else if (!run_in) begin
      count    <= '0;
      done_out <= 1'b0;
    end else if (!done_out) begin
      if (count == LIMIT - 24'h000001) begin
        done_out <= 1'b1;
      end else begin
        count <= count + 24'h000001;
      end
    end
  end

endmodule

// ===== testbench/plc_ctrl_model.sv
`timescale 1ns/10ps
module plc_ctrl_model #(
  parameter logic [5:0] SENS_TRIM_ADDR = 6'h01,
  parameter logic [5:0] ZERO_TRIM_ADDR = 6'h02
) (
  input  wire logic         core_clk_in,
  output logic              cmd_valid_out,
  output plc_pkg::plc_cmd_t cmd_out
);
  // ---------------------------------------------------------------
  // Idle state of the decoded command lines
  // ---------------------------------------------------------------
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out       = '0;
  end

  // One strobe per frame, launched and released on falling edges
  task automatic send(input plc_pkg::plc_cmd_kind_t kind, input logic [5:0] addr,
                      input logic [29:0] data);
    @(negedge core_clk_in);
    cmd_out       = {kind, addr, data};
    cmd_valid_out = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    cmd_out       = ~cmd_out;  // Stale frame must never look reusable
  endtask

  // Unlock frame goes to the key register as an access command, sent whenever the caller invokes it
  task automatic unlock(input logic [29:0] key);
    send(plc_pkg::CMD_ACCESS, plc_pkg::UNLOCK_KEY_ADDR, key);
  endtask

  // Sensitivity first, since it nudges the zero field level
  task automatic trim_pair(input logic [29:0] sens, input logic [29:0] zero_lvl);
    send(plc_pkg::CMD_VOL_WR, SENS_TRIM_ADDR, sens);
    send(plc_pkg::CMD_VOL_WR, ZERO_TRIM_ADDR, zero_lvl);
  endtask
endmodule

// ===== testbench/power_on_lock_control_tb.sv
`timescale 1ns/10ps
module power_on_lock_control_tb;
  localparam logic [23:0] WIN_CYC = 24'h0000c8;
  localparam logic [23:0] REL_CYC = 24'h000014;
  localparam logic [29:0] KEY     = 30'h13572468;  // Arbitrary test key

  logic                     core_clk_in, rst_n_in, rise, fall, gnd_ok, perm, cmd_valid;
  logic                     por_rst_n, drive_en, track, refused, accepted, win_open;
  plc_pkg::plc_cmd_t        cmd, grant_cmd;
  plc_pkg::plc_grant_t      grant;
  plc_pkg::plc_lock_state_t lock_st;
  int                       errors, comparisons, cycles;

  // ---------------------------------------------------------------
  // Clock, instances, timeout
  // ---------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  plc_top #(.UNLOCK_WINDOW_CYC(WIN_CYC), .RELEASE_CYC(REL_CYC), .UNLOCK_KEY(KEY))
  plc_top_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .supply_above_rise_in(rise),
    .supply_above_fall_in(fall), .ground_ok_in(gnd_ok), .perm_lock_bit_in(perm),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .por_reset_n_out(por_rst_n),
    .out_drive_en_out(drive_en), .field_track_out(track), .grant_out(grant),
    .grant_cmd_out(grant_cmd), .cmd_refused_out(refused), .unlock_accepted_out(accepted),
    .lock_state_out(lock_st), .window_open_out(win_open));

  plc_ctrl_model plc_ctrl_model_inst (
    .core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));

  // Ceiling well above the roughly 330 cycles the run needs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [37:0] got, input logic [37:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Response vector {vol_wr, nv_wr, rd, refused, accepted}, one edge after taking
  task automatic cmd_expect(input plc_pkg::plc_cmd_kind_t kind, input logic [5:0] addr,
                            input logic [29:0] data, input logic [4:0] exp, input string msg);
    plc_ctrl_model_inst.send(kind, addr, data);
    check({grant, refused, accepted}, exp, msg);
  endtask

  // Count must run out in full before the pin is driven
  task automatic power_up();
    int n;
    n = 0;
    @(negedge core_clk_in);
    rise = 1'b1;
    fall = 1'b1;
    repeat (REL_CYC) @(negedge core_clk_in);
    check(drive_en, 1'b0, "output driven before release count");
    while (drive_en !== 1'b1 && n < 12) begin
      @(negedge core_clk_in);
      n++;
    end
    check({por_rst_n, drive_en, track}, 3'h7, "no release after count");
  endtask

  // Drop below lower threshold, then a rise that is lost mid-count
  task automatic power_down();
    @(negedge core_clk_in);
    rise = 1'b0;
    fall = 1'b0;
    repeat (4) @(negedge core_clk_in);
    check({por_rst_n, drive_en}, 2'h0, "output still driven after fall");
    rise = 1'b1;
    fall = 1'b1;
    repeat (10) @(negedge core_clk_in);
    rise = 1'b0;
    repeat (4) @(negedge core_clk_in);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_locked();
    power_up();
    cmd_expect(plc_pkg::CMD_READ, 6'h01, '0, 5'h02, "read while locked");
    cmd_expect(plc_pkg::CMD_VOL_WR, 6'h01, '0, 5'h02, "vol write while locked");
    cmd_expect(plc_pkg::CMD_NV_WR, 6'h01, '0, 5'h02, "nv write while locked");
    cmd_expect(plc_pkg::CMD_ACCESS, 6'h24, KEY ^ 30'h1, 5'h02, "bad key taken");
    cmd_expect(plc_pkg::CMD_ACCESS, 6'h25, KEY, 5'h02, "wrong key address");
    check(lock_st, plc_pkg::LK_LOCKED, "lock opened by bad access");
  endtask

  task automatic test_ground();
    gnd_ok = 1'b0;
    repeat (5) @(negedge core_clk_in);
    check({drive_en, track}, 2'h0, "output live with ground lost");
    gnd_ok = 1'b1;
    repeat (5) @(negedge core_clk_in);
    check({drive_en, track}, 2'h3, "no recovery after ground back");
  endtask

  task automatic test_unlock();
    plc_ctrl_model_inst.unlock(KEY);
    check({grant, refused, accepted}, 5'h01, "good key not accepted");
    @(negedge core_clk_in);
    check(lock_st, plc_pkg::LK_OPEN, "lock not open");
    cmd_expect(plc_pkg::CMD_NV_WR, 6'h03, 30'h00abcd, 5'h08, "nv write");
    cmd_expect(plc_pkg::CMD_READ, 6'h03, '0, 5'h04, "read");
    plc_ctrl_model_inst.trim_pair(30'h000123, 30'h000456);
    check({grant, refused, accepted}, 5'h10, "vol write not granted");
    check(grant_cmd, {plc_pkg::CMD_VOL_WR, 6'h02, 30'h000456}, "last granted cmd");
    cmd_expect(plc_pkg::CMD_ACCESS, 6'h24, KEY, 5'h00, "second unlock pulsed");
  endtask

  task automatic test_power_cycle();
    power_down();
    power_up();
    check(lock_st, plc_pkg::LK_LOCKED, "lock not restored");
    cmd_expect(plc_pkg::CMD_READ, 6'h01, '0, 5'h02, "read after power cycle");
  endtask

  task automatic test_late();
    int n;
    n = 0;
    while (win_open !== 1'b0 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    check(win_open, 1'b0, "window never closed");
    cmd_expect(plc_pkg::CMD_ACCESS, 6'h24, KEY, 5'h02, "late key taken");
    check(lock_st, plc_pkg::LK_LOCKED, "late key opened lock");
  endtask

  task automatic test_perm();
    perm = 1'b1;
    power_down();
    power_up();
    cmd_expect(plc_pkg::CMD_ACCESS, 6'h24, KEY, 5'h02, "key under permanent lock");
    cmd_expect(plc_pkg::CMD_READ, 6'h01, '0, 5'h02, "read under permanent lock");
    check(lock_st, plc_pkg::LK_PERM, "permanent lock missing");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    errors      = 0;
    comparisons = 0;
    cycles      = 0;
    rst_n_in    = 1'b0;
    rise        = 1'b0;
    fall        = 1'b0;
    gnd_ok      = 1'b1;
    perm        = 1'b0;
    repeat (5) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    test_locked();
    test_ground();
    test_unlock();
    test_power_cycle();
    test_late();
    test_perm();
    stop_test();
  end
endmodule
